/* core/msp_port.sv */
// Purpose: Serial secondary register port, standard and multi-drop
// Assumes: Link clock far slower than clk_sys_in (8 cycles or more)
// Notes:   Accepted writes queue in a FIFO and drain to the core
`timescale 1ns/1ns
module msp_port
  import msp_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        sclk_in,
  input  wire logic        mosi_in,
  input  wire logic        id_select_pin0_in,
  input  wire logic        id_select_pin1_in,
  input  wire logic        format_select_in,
  input  wire logic [15:0] dev_status_one_in,
  input  wire logic [15:0] ot_status_in,
  input  wire logic [15:0] supply_status_in,
  input  wire logic [15:0] driver_status_in,
  input  wire logic        cfg_wr_ready_in,
  output logic             miso_out,
  output logic             miso_oe_b_out,
  output logic             fault_out_n_out,
  output logic             cfg_wr_valid_out,
  output logic [7:0]       cfg_wr_addr_out,
  output logic [15:0]      cfg_wr_data_out
);

  typedef struct packed {
    logic [MSP_PIN_W-1:0] pin_s1;
    logic [MSP_PIN_W-1:0] pin_s2;
    logic                 sclk_s3;
    logic                 cs_s3;
    msp_phase_t           phase;
    logic [3:0]           cnt;
    logic [15:0]          rx;
    logic [15:0]          tx;
    logic                 md;
    logic                 id_ok;
    logic                 wr_ok;
    logic                 is_rd;
    logic                 wr_block;
    logic [7:0]           rptr;
    logic [7:0]           wptr;
    logic                 par_flag;
    logic                 frm_flag;
    logic                 ovf_flag;
    logic                 miso;
    logic                 miso_oe_b;
    logic                 fault_n;
    logic                 wv;
    logic [7:0]           waddr;
    logic [15:0]          wdata;
    logic [63:0][15:0]    regs;
  } msp_port_st_t;

  msp_port_st_t           st_ff;
  msp_port_st_t           nxt_st;
  logic                   pen;
  logic [15:0]            ds1;
  logic [15:0]            system_status;
  logic                   cs_fall;
  logic                   cs_rise;
  logic                   sclk_rise;
  logic                   fall_ev;
  logic                   push;
  logic [MSP_FIFO_W-1:0]  push_data;
  logic                   fifo_rdy;
  logic                   fifo_ov;
  logic                   fifo_or;
  logic [MSP_FIFO_W-1:0]  fifo_od;
  logic                   bad_word;
  logic                   tx_load;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic is_writable(input logic [7:0] a);
    return a inside {MSP_OFS_SYNC_PRD, MSP_OFS_FAULT_MODE, MSP_OFS_SYSF_CTL,
                     MSP_OFS_DRVF_CTL, MSP_OFS_FLT_TCTL, MSP_OFS_FAULT_CLEAR,
                     MSP_OFS_GEN_PRD, MSP_OFS_DUTY_A, MSP_OFS_DUTY_B,
                     MSP_OFS_DUTY_C, MSP_OFS_OUT_STATE, MSP_OFS_GEN_CTL,
                     MSP_OFS_MOD_CTL1, MSP_OFS_PRE_CTL, MSP_OFS_CSA_CTL,
                     MSP_OFS_SYS_CTL};
  endfunction

  function automatic logic [15:0] rd_word(input logic [7:0] a);
    logic [15:0] w;
    w = MSP_REG_RST;
    if (a == MSP_OFS_DEVICE_STATUS_ONE) begin
      w = ds1;
    end else if (a == MSP_OFS_OVERTEMPERATURE_STATUS) begin
      w = ot_status_in;
    end else if (a == MSP_OFS_SUPPLY_STATUS) begin
      w = supply_status_in;
    end else if (a == MSP_OFS_DRIVER_STATUS) begin
      w = driver_status_in;
    end else if (a == MSP_OFS_SYSTEM_STATUS) begin
      w = system_status;
    end else if (is_writable(a)) begin
      w = st_ff.regs[a[5:0]];
    end
    if (pen) begin
      w[MSP_PAR_BIT] = ^w[MSP_PAR_BIT-1:0];
    end
    return w;
  endfunction

  assign pen = st_ff.regs[MSP_OFS_SYS_CTL[5:0]][MSP_PEN_BIT];

  always_comb begin
    system_status = MSP_REG_RST;
    system_status[MSP_SYS_PAR_BIT] = st_ff.par_flag;
    system_status[MSP_SYS_FRM_BIT] = st_ff.frm_flag;
    system_status[MSP_SYS_OVF_BIT] = st_ff.ovf_flag;
    ds1 = dev_status_one_in;
    ds1[MSP_DS1_SPI_BIT] = st_ff.par_flag | st_ff.frm_flag | st_ff.ovf_flag;
  end

  // Edges come from the second and third stages only
  assign cs_fall   = st_ff.cs_s3 && !st_ff.pin_s2[MSP_PIN_CS];
  assign cs_rise   = !st_ff.cs_s3 && st_ff.pin_s2[MSP_PIN_CS];
  assign sclk_rise = !st_ff.sclk_s3 && st_ff.pin_s2[MSP_PIN_SCLK];
  assign fall_ev   = st_ff.sclk_s3 && !st_ff.pin_s2[MSP_PIN_SCLK] &&
                     (st_ff.phase != MSP_PH_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Write queue

  msp_fifo #(
    .W (MSP_FIFO_W),
    .D (MSP_FIFO_D)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_rdy),
    .in_data_in    (push_data),
    .out_valid_out (fifo_ov),
    .out_ready_in  (fifo_or),
    .out_data_out  (fifo_od)
  );

  assign fifo_or = !st_ff.wv || cfg_wr_ready_in;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [15:0] rx_n;
    logic [7:0]  hdr_a;
    logic        hdr_rw;
    logic        hdr_bad;
    rx_n      = {st_ff.rx[14:0], st_ff.pin_s2[MSP_PIN_MOSI]};
    hdr_a     = '0;
    hdr_rw    = 1'b0;
    hdr_bad   = 1'b0;
    nxt_st    = st_ff;
    push      = 1'b0;
    push_data = {st_ff.wptr, rx_n};
    tx_load   = 1'b0;
    bad_word  = pen && (^rx_n);

    nxt_st.pin_s1 = {chip_select_n_in, sclk_in, mosi_in,
                     id_select_pin1_in, id_select_pin0_in, format_select_in};
    nxt_st.pin_s2  = st_ff.pin_s1;
    nxt_st.sclk_s3 = st_ff.pin_s2[MSP_PIN_SCLK];
    nxt_st.cs_s3   = st_ff.pin_s2[MSP_PIN_CS];

    // Drain stage: clears first so that a new error wins
    if (st_ff.wv && cfg_wr_ready_in) begin
      nxt_st.wv = 1'b0;
      if (is_writable(st_ff.waddr)) begin
        nxt_st.regs[st_ff.waddr[5:0]] = st_ff.wdata;
      end
      if (st_ff.waddr == MSP_OFS_FAULT_CLEAR && st_ff.wdata[MSP_CLR_BIT]) begin
        nxt_st.par_flag = 1'b0;
        nxt_st.frm_flag = 1'b0;
        nxt_st.ovf_flag = 1'b0;
      end
    end
    if (fifo_ov && fifo_or) begin
      nxt_st.wv = 1'b1;
      {nxt_st.waddr, nxt_st.wdata} = fifo_od;
    end

    if (cs_fall) begin
      nxt_st.phase    = MSP_PH_HDR;
      nxt_st.cnt      = '0;
      nxt_st.md       = st_ff.pin_s2[MSP_PIN_FMT];
      nxt_st.id_ok    = !st_ff.pin_s2[MSP_PIN_FMT];
      nxt_st.wr_ok    = !st_ff.pin_s2[MSP_PIN_FMT];
      nxt_st.wr_block = 1'b0;
      nxt_st.tx       = {ds1[7:0], 8'h00};
    end else if (cs_rise) begin
      nxt_st.phase = MSP_PH_IDLE;
      // Partial words are dropped; only the flag records them
      if (st_ff.wr_ok && (st_ff.phase == MSP_PH_HDR ||
                          st_ff.cnt != '0)) begin
        nxt_st.frm_flag = 1'b1;
      end
    end else if (st_ff.phase != MSP_PH_IDLE && sclk_rise) begin
      nxt_st.miso = st_ff.tx[15];
      nxt_st.tx   = {st_ff.tx[14:0], 1'b0};
    end else if (fall_ev) begin
      nxt_st.rx  = rx_n;
      nxt_st.cnt = st_ff.cnt + 4'h1;
      unique case (st_ff.phase)
        MSP_PH_HDR: begin
          if (st_ff.md && st_ff.cnt == MSP_ID_LAST) begin
            nxt_st.id_ok = (rx_n[3:0] == {2'b00,
                            st_ff.pin_s2[MSP_PIN_ID1],
                            st_ff.pin_s2[MSP_PIN_ID0]});
            nxt_st.wr_ok = nxt_st.id_ok ||
                           (rx_n[3:0] == MSP_GC_ID);
          end
          if (st_ff.md && st_ff.cnt == MSP_CNT_LAST) begin
            hdr_rw  = rx_n[MSP_MD_RW];
            hdr_a   = rx_n[MSP_MD_A_MSB -: 8];
            hdr_bad = bad_word;
          end else if (!st_ff.md && st_ff.cnt == MSP_STD_HDR_LAST) begin
            hdr_rw  = rx_n[MSP_STD_RW];
            hdr_a   = {2'b00, rx_n[MSP_STD_A_MSB -: 6]};
            hdr_bad = pen && (^rx_n[7:0]);
          end
          if ((st_ff.md && st_ff.cnt == MSP_CNT_LAST) ||
              (!st_ff.md && st_ff.cnt == MSP_STD_HDR_LAST)) begin
            nxt_st.phase    = MSP_PH_DATA;
            nxt_st.cnt      = '0;
            nxt_st.is_rd    = (hdr_rw == MSP_RW_READ);
            nxt_st.wr_block = hdr_bad;
            if (hdr_bad && nxt_st.wr_ok) begin
              nxt_st.par_flag = 1'b1;
            end
            // Bad read header still loads the pointer and answers
            if (hdr_rw == MSP_RW_READ && nxt_st.id_ok) begin
              nxt_st.rptr = hdr_a;
            end
            if (hdr_rw != MSP_RW_READ && nxt_st.wr_ok && !hdr_bad) begin
              nxt_st.wptr = hdr_a;
            end
            if (nxt_st.id_ok) begin
              nxt_st.tx = rd_word(nxt_st.rptr);
              tx_load   = 1'b1;
            end
          end
        end
        MSP_PH_DATA: begin
          if (st_ff.cnt == MSP_CNT_LAST) begin
            if (!st_ff.is_rd && st_ff.wr_ok) begin
              if (bad_word) begin
                nxt_st.par_flag = 1'b1;
                nxt_st.wr_block = 1'b1;
              end else if (!st_ff.wr_block) begin
                // No stall on the link: a full queue loses the word
                push            = fifo_rdy;
                nxt_st.ovf_flag = st_ff.ovf_flag | !fifo_rdy;
              end
              nxt_st.wptr = st_ff.wptr + 8'h01;
              nxt_st.rptr = st_ff.rptr + 8'h01;
            end else if (st_ff.is_rd && st_ff.id_ok) begin
              nxt_st.rptr = st_ff.rptr + 8'h01;
            end
            if (st_ff.id_ok) begin
              nxt_st.tx = rd_word(nxt_st.rptr);
              tx_load   = 1'b1;
            end
          end
        end
        MSP_PH_IDLE: begin
        end
      endcase
    end

    nxt_st.miso_oe_b = !((nxt_st.phase != MSP_PH_IDLE) &&
                         nxt_st.id_ok);
    nxt_st.fault_n = !(nxt_st.par_flag | nxt_st.frm_flag |
                       nxt_st.ovf_flag);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st_ff           <= '0;
      st_ff.miso_oe_b <= 1'b1;
      st_ff.fault_n   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign miso_out         = st_ff.miso;
  assign miso_oe_b_out    = st_ff.miso_oe_b;
  assign fault_out_n_out  = st_ff.fault_n;
  assign cfg_wr_valid_out = st_ff.wv;
  assign cfg_wr_addr_out  = st_ff.waddr;
  assign cfg_wr_data_out  = st_ff.wdata;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_word_end;
    st_ff.phase == MSP_PH_DATA && fall_ev && st_ff.cnt == MSP_CNT_LAST;
  endsequence

  sequence s_rd_word;
    s_word_end ##0 (st_ff.is_rd && st_ff.id_ok);
  endsequence

  AST_IDLE_HIZ: assert property (
    (st_ff.cs_s3 && st_ff.pin_s2[MSP_PIN_CS]) |=> miso_oe_b_out)
    else $error("data out driven while deselected");

  AST_PAR_FAULT: assert property (
    $rose(st_ff.par_flag) |-> !fault_out_n_out && system_status[MSP_SYS_PAR_BIT])
    else $error("parity error not reported");

  AST_PEN_GATE: assert property (
    $rose(st_ff.par_flag) |-> $past(pen))
    else $error("parity error while checking disabled");

  AST_FRAME_ERR: assert property (
    (cs_rise && st_ff.wr_ok && st_ff.phase == MSP_PH_DATA &&
     st_ff.cnt != '0) |=> st_ff.frm_flag ##1 !fault_out_n_out)
    else $error("short frame not flagged");

  AST_NO_WR_BLOCKED: assert property (
    push |-> !st_ff.wr_block && !bad_word && !st_ff.is_rd)
    else $error("write accepted after parity error");

  AST_RPTR_STEP: assert property (
    s_rd_word |=> st_ff.rptr == $past(st_ff.rptr) + 8'h01)
    else $error("read pointer did not step");

  AST_PAR_MSB: assert property (
    (tx_load && pen) |=> (^st_ff.tx) == 1'b0)
    else $error("read word parity not even");

  AST_MISMATCH: assert property (
    (st_ff.phase != MSP_PH_IDLE && !st_ff.wr_ok) |-> !push ##1
    $stable(st_ff.wptr))
    else $error("unaddressed device changed state");

endmodule // msp_port

/* core/msp_pkg.sv */
// Purpose: Constants and types of the multi-drop serial register port
// Assumes: One system clock; link pins are sampled, not used as clocks
// Notes:   Offsets are register indexes on the serial link
package msp_pkg;

  localparam logic [7:0] MSP_OFS_DEVICE_STATUS_ONE  = 8'h00;
  localparam logic [7:0] MSP_OFS_OVERTEMPERATURE_STATUS    = 8'h04;
  localparam logic [7:0] MSP_OFS_SUPPLY_STATUS   = 8'h05;
  localparam logic [7:0] MSP_OFS_DRIVER_STATUS   = 8'h06;
  localparam logic [7:0] MSP_OFS_SYSTEM_STATUS   = 8'h07;
  localparam logic [7:0] MSP_OFS_SYNC_PRD  = 8'h0c;
  localparam logic [7:0] MSP_OFS_FAULT_MODE  = 8'h10;
  localparam logic [7:0] MSP_OFS_SYSF_CTL  = 8'h12;
  localparam logic [7:0] MSP_OFS_DRVF_CTL  = 8'h13;
  localparam logic [7:0] MSP_OFS_FLT_TCTL  = 8'h16;
  localparam logic [7:0] MSP_OFS_FAULT_CLEAR   = 8'h17;
  localparam logic [7:0] MSP_OFS_GEN_PRD   = 8'h18;
  localparam logic [7:0] MSP_OFS_DUTY_A    = 8'h19;
  localparam logic [7:0] MSP_OFS_DUTY_B    = 8'h1a;
  localparam logic [7:0] MSP_OFS_DUTY_C    = 8'h1b;
  localparam logic [7:0] MSP_OFS_OUT_STATE = 8'h1c;
  localparam logic [7:0] MSP_OFS_GEN_CTL   = 8'h1d;
  localparam logic [7:0] MSP_OFS_MOD_CTL1  = 8'h20;
  localparam logic [7:0] MSP_OFS_PRE_CTL   = 8'h22;
  localparam logic [7:0] MSP_OFS_CSA_CTL   = 8'h23;
  localparam logic [7:0] MSP_OFS_SYS_CTL   = 8'h3f;

  localparam logic [15:0] MSP_REG_RST = 16'h0000;

  // Field positions
  localparam int MSP_SYS_PAR_BIT = 0;
  localparam int MSP_SYS_FRM_BIT = 1;
  localparam int MSP_SYS_OVF_BIT = 2;
  localparam int MSP_DS1_SPI_BIT = 6;
  localparam int MSP_PEN_BIT     = 0;
  localparam int MSP_CLR_BIT     = 0;
  localparam int MSP_PAR_BIT     = 15;

  // Synchroniser lanes
  localparam int MSP_PIN_W    = 6;
  localparam int MSP_PIN_CS   = 5;
  localparam int MSP_PIN_SCLK = 4;
  localparam int MSP_PIN_MOSI = 3;
  localparam int MSP_PIN_ID1  = 2;
  localparam int MSP_PIN_ID0  = 1;
  localparam int MSP_PIN_FMT  = 0;

  // Header layout and bit counts
  localparam logic [3:0] MSP_STD_HDR_LAST = 4'h7;
  localparam logic [3:0] MSP_ID_LAST      = 4'h4;
  localparam logic [3:0] MSP_CNT_LAST     = 4'hf;
  localparam int         MSP_STD_RW       = 7;
  localparam int         MSP_STD_A_MSB    = 6;
  localparam int         MSP_MD_RW        = 15;
  localparam int         MSP_MD_A_MSB     = 10;
  localparam logic [3:0] MSP_GC_ID        = 4'hf;
  localparam logic       MSP_RW_READ      = 1'b1;

  localparam int MSP_FIFO_W = 24;
  localparam int MSP_FIFO_D = 8;

  typedef enum logic [1:0] {
    MSP_PH_IDLE = 2'b00,
    MSP_PH_HDR  = 2'b01,
    MSP_PH_DATA = 2'b10
  } msp_phase_t;

endpackage

/* core/msp_fifo.sv */
// Purpose: Small FIFO for accepted register writes
// Assumes: Same clock on both sides
// Notes:   Full and empty come straight from the fill count
`timescale 1ns/1ns
module msp_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_b_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);

  localparam int           AW   = $clog2(D);
  localparam logic [AW:0]  FULL = (AW+1)'(D);
  localparam logic [AW-1:0] LAST = (AW)'(D - 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } msp_fifo_st_t;

  msp_fifo_st_t st_ff;
  msp_fifo_st_t nxt_st;
  logic         push;
  logic         pop;

  assign in_ready_out  = (st_ff.cnt != FULL);
  assign out_valid_out = (st_ff.cnt != '0);
  assign out_data_out  = st_ff.mem[st_ff.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data_in;
      nxt_st.wp = (st_ff.wp == LAST) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == LAST) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // msp_fifo

/* tb/msp_host.sv */
// Purpose: Link primary model driving select, clock and data
// Assumes: 160 ns link clock that runs only inside frames
// Notes:   Returned data is taken just after each falling edge
`timescale 1ns/1ns
module msp_host (
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock is low at both select edges
  task automatic sel();
    #7 cs_n_out = 1'b0;
    #93;
  endtask

  task automatic desel();
    #40 cs_n_out = 1'b1;
    #160;
  endtask

  // Launch on rise, sample on fall, MSB first
  task automatic shift(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out = 1'b1;
      mosi_out = tx[i];
      #80 sclk_out = 1'b0;
      #2 rx = {rx[14:0], miso_in};
      #78;
    end
  endtask
endmodule // msp_host

/* tb/msp_port_bench.sv */
// Purpose: Self-checking bench of the serial register port
// Assumes: Secondary ID pins set to 2; writes drain at once unless stalled
// Notes:   Undriven data line shows the inverse of its last level
`timescale 1ns/1ns
module msp_port_bench;
  import msp_pkg::*;
  localparam logic [3:0] MY_ID = 4'h2;
  logic        clk = 1'b0;
  logic        rst_b, cs_n, sclk, mosi, fmt, wr_rdy, miso, oe_b, flt_n, wv;
  logic        miso_last = 1'b0;
  logic [1:0]  id_pins = 2'b10;
  logic [7:0]  wa;
  logic [15:0] wd, rx;
  logic [15:0] tx_q[$];
  logic [15:0] rx_q[$];
  int          bad_count = 0;
  int          samples_checked = 0;
  int          acc = 0;
  int          a0;
  int          oe_cnt = 0;
  int          oe0;
  wire         miso_w = oe_b ? ~miso_last : miso;

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (!oe_b) begin
      oe_cnt <= oe_cnt + 1;
      miso_last <= miso;
    end
    if (wv && wr_rdy) acc <= acc + 1;
  end

  msp_port DUT (
    .clk_sys_in(clk), .rst_b_in(rst_b), .chip_select_n_in(cs_n),
    .sclk_in(sclk), .mosi_in(mosi), .id_select_pin0_in(id_pins[0]),
    .id_select_pin1_in(id_pins[1]), .format_select_in(fmt),
    .dev_status_one_in(16'h0081), .ot_status_in(16'h0003),
    .supply_status_in(16'h0050), .driver_status_in(16'h0600),
    .cfg_wr_ready_in(wr_rdy), .miso_out(miso), .miso_oe_b_out(oe_b),
    .fault_out_n_out(flt_n), .cfg_wr_valid_out(wv),
    .cfg_wr_addr_out(wa), .cfg_wr_data_out(wd));

  msp_host host_model (.cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi),
    .miso_in(miso_w));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Even parity over the whole header
  function automatic logic [15:0] md_hdr(logic rw, logic [3:0] sid,
                                         logic [7:0] a);
    logic [15:0] h;
    h = {rw, sid, a, 3'b000};
    h[0] = ^h[15:1];
    return h;
  endfunction

  function automatic logic [15:0] par(logic [15:0] d);
    return {^d[14:0], d[14:0]};
  endfunction

  task automatic drain();
    for (int k = 0; k < 100 && wv; k++) @(posedge clk);
    chk("write drain", {15'h0, wv}, 16'h0000);
    if (wv) final_report();
  endtask

  task automatic run(input logic [15:0] h, input int hn);
    logic [15:0] r;
    oe0 = oe_cnt;
    rx_q = {};
    host_model.sel();
    host_model.shift(h, hn, r);
    rx_q.push_back(r);
    foreach (tx_q[i]) begin
      host_model.shift(tx_q[i], 16, r);
      rx_q.push_back(r);
    end
    host_model.desel();
    tx_q = {};
    if (wr_rdy) drain();
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e0, e1);
    tx_q = '{16'h0000, 16'h0000};
    run(md_hdr(1'b1, MY_ID, a), 16);
    chk("read word", rx_q[1], e0);
    chk("next word", rx_q[2], e1);
  endtask

  task automatic wr(input logic [3:0] sid, input logic [7:0] a,
                    input logic [15:0] d);
    tx_q.push_back(d);
    run(md_hdr(1'b0, sid, a), 16);
  endtask

  task automatic clear();
    wr(MY_ID, MSP_OFS_FAULT_CLEAR, 16'h0001);
    chk("fault released", {15'h0, flt_n}, 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    fmt = 1'b0;
    wr_rdy = 1'b1;
    repeat (2) @(posedge clk);
    #2 rst_b = 1'b1;
    repeat (6) @(posedge clk);
    chk("idle enable", {15'h0, oe_b}, 16'h0001);
    tx_q = '{16'h0000};
    run({8'h00, 1'b1, 6'h04, 1'b0}, 8);
    chk("status byte", rx_q[0], 16'h0081);
    chk("standard read", rx_q[1], 16'h0003);
    chk("enable after frame", {15'h0, oe_b}, 16'h0001);
    @(posedge clk);
    #2 fmt = 1'b1;
    tx_q = '{16'h1234, 16'h0567};
    run(md_hdr(1'b0, MY_ID, MSP_OFS_DUTY_A), 16);
    chk("data during write", rx_q[1], 16'h0050);
    chk("next during write", rx_q[2], 16'h0600);
    rd(MSP_OFS_DUTY_A, 16'h1234, 16'h0567);
    run(md_hdr(1'b1, MY_ID, MSP_OFS_DUTY_A), 16);
    wr(MY_ID, MSP_OFS_DUTY_C, 16'h0abc);
    chk("read during write", rx_q[1], 16'h1234);
    rd(MSP_OFS_DUTY_B, 16'h0567, 16'h0abc);
    wr(4'h1, MSP_OFS_DUTY_A, 16'h7777);
    chk("other id silent", oe_cnt - oe0, 16'h0000);
    wr(MSP_GC_ID, MSP_OFS_OUT_STATE, 16'h0042);
    chk("broadcast silent", oe_cnt - oe0, 16'h0000);
    rd(MSP_OFS_DUTY_A, 16'h1234, 16'h0567);
    rd(MSP_OFS_OUT_STATE, 16'h0042, 16'h0000);
    // Short frame: five clocks past the header
    host_model.sel();
    host_model.shift(md_hdr(1'b1, MY_ID, MSP_OFS_SYSTEM_STATUS), 16, rx);
    host_model.shift(16'h0000, 5, rx);
    host_model.desel();
    chk("fault on short frame", {15'h0, flt_n}, 16'h0000);
    rd(MSP_OFS_SYSTEM_STATUS, 16'h0002, 16'h0000);
    clear();
    // Queue stalled: holding stage plus eight slots, tenth word lost
    @(posedge clk);
    #2 wr_rdy = 1'b0;
    a0 = acc;
    for (int i = 0; i < 10; i++) begin
      wr(MY_ID, MSP_OFS_PRE_CTL, {8'h00, i[3:0], 4'h1});
    end
    chk("valid held", {15'h0, wv}, 16'h0001);
    chk("held address", {8'h00, wa}, {8'h00, MSP_OFS_PRE_CTL});
    chk("held data", wd, 16'h0001);
    @(posedge clk);
    #2 wr_rdy = 1'b1;
    drain();
    chk("accepted words", acc - a0, 16'h0009);
    rd(MSP_OFS_PRE_CTL, 16'h0081, 16'h0000);
    rd(MSP_OFS_SYSTEM_STATUS, 16'h0004, 16'h0000);
    clear();
    wr(MY_ID, MSP_OFS_SYS_CTL, 16'h0001);
    rd(MSP_OFS_DUTY_A, 16'h9234, 16'h8567);
    tx_q.push_back(par(16'h0111));
    run(md_hdr(1'b0, MY_ID, MSP_OFS_DUTY_A) ^ 16'h0001, 16);
    chk("fault on parity", {15'h0, flt_n}, 16'h0000);
    tx_q = '{16'h0000};
    run(md_hdr(1'b1, MY_ID, MSP_OFS_DUTY_A) ^ 16'h0001, 16);
    chk("read despite bad header", rx_q[1], 16'h9234);
    rd(MSP_OFS_SYSTEM_STATUS, 16'h8001, 16'h0000);
    tx_q = '{par(16'h0222), par(16'h0123) ^ 16'h0001, par(16'h0333)};
    run(md_hdr(1'b0, MY_ID, MSP_OFS_DUTY_B), 16);
    rd(MSP_OFS_DUTY_B, 16'h8222, 16'h8abc);
    rd(MSP_OFS_OUT_STATE, 16'h0042, 16'h0000);
    final_report();
  end
endmodule // msp_port_bench
